// >>> hw/eob_pkg.sv
// Package: register numbers, widths and timing for the expansion output bank
package eob_pkg;
  localparam int unsigned EOB_REG_NUM_W = 16;
  localparam int unsigned EOB_DATA_W = 32;
  localparam int unsigned EOB_OUT_COUNT = 96;
  localparam int unsigned EOB_HALF_COUNT = 6;
  // Register numbers as seen by serial, Modbus and macro access
  localparam logic [15:0] EOB_WORD_A_NUM = 16'h00f9;
  localparam logic [15:0] EOB_WORD_B_NUM = 16'h00fd;
  localparam logic [15:0] EOB_A_LOW_NUM = 16'h1164;
  localparam logic [15:0] EOB_A_HIGH_NUM = 16'h1165;
  localparam logic [15:0] EOB_B_LOW_NUM = 16'h1166;
  localparam logic [15:0] EOB_B_HIGH_NUM = 16'h1167;
  localparam logic [15:0] EOB_C_LOW_NUM = 16'h1168;
  localparam logic [15:0] EOB_C_HIGH_NUM = 16'h1169;
  localparam logic [95:0] EOB_FLAGS_RESET = 96'h0000_0000_0000_0000_0000_0000;
  // Refresh period toward the expansion modules
  localparam int unsigned EOB_CLK_MHZ = 200;
  localparam int unsigned EOB_REFRESH_MS = 100;
  localparam int unsigned EOB_REFRESH_CYCLES = EOB_REFRESH_MS * 1000 * EOB_CLK_MHZ;
  localparam int unsigned EOB_TICK_W = 25;
endpackage

// >>> hw/eob_refresh_tick.sv
// Divider that emits the one-cycle refresh enable
`timescale 1ns/1ps
module eob_refresh_tick #(
  parameter int unsigned PERIOD = eob_pkg::EOB_REFRESH_CYCLES
) (
  input wire logic mclk,
  input wire logic nrst,
  output logic tick
);
  import eob_pkg::*;

  typedef struct packed {
    logic [EOB_TICK_W-1:0] count;
    logic tick;
  } eob_tick_state_type;

  eob_tick_state_type state_reg;
  eob_tick_state_type state_next;
  localparam logic [EOB_TICK_W-1:0] LAST = EOB_TICK_W'(PERIOD - 1);

  always_comb begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (state_reg.count >= LAST) begin
      state_next.count = '0;
      state_next.tick = 1'b1;
    end else begin
      state_next.count = state_reg.count + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick = state_reg.tick;

  tick_spacing_a: assert property (@(posedge mclk) disable iff (!nrst)
    tick |=> !tick) else $error("refresh tick lasted more than one cycle");
endmodule

// >>> hw/eob_bank.sv
// Expansion digital output flag bank with aliased 32-bit and 16-bit views
`timescale 1ns/1ps
// Overview of operation
// - Word A bits 0..31 map one to one onto expansion outputs 1..32.
// - A flag reads and drives 1 for active and 0 for inactive.
// - The A low half view bits 0..15 are outputs 1..16, the low half of word A.
// - The A high half view bits 0..15 are outputs 17..32, the high half of word A.
// - Word B bits 0..31 hold outputs 33..64.
// - The B low and high half views alias word B as outputs 33..48 and 49..64.
// - Outputs 65..96 are reached only through the C low and high half views.
// - Every flag register is readable and writable, reads show the stored flags, which reach ext_out only at the next refresh.
// - For outputs 1..64 both the 32-bit words and the 16-bit halves are offered for the same flags.
// - Flags pass to the modules on a periodic 100 ms refresh, not at once.
module eob_bank #(
  parameter int unsigned REFRESH_CYCLES = eob_pkg::EOB_REFRESH_CYCLES
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [eob_pkg::EOB_REG_NUM_W-1:0] reg_num,
  input wire logic [eob_pkg::EOB_DATA_W-1:0] reg_wdata,
  output logic [eob_pkg::EOB_DATA_W-1:0] reg_rdata,
  output logic reg_hit,
  output logic [eob_pkg::EOB_OUT_COUNT-1:0] ext_out,
  output logic ext_refresh
);
  import eob_pkg::*;

  // ********************************
  // State
  // ********************************
  typedef struct packed {
    logic [EOB_OUT_COUNT-1:0] flags;
    logic [EOB_OUT_COUNT-1:0] pins;
    logic [EOB_DATA_W-1:0] rdata;
  } eob_state_type;

  eob_state_type state_reg;
  eob_state_type state_next;
  logic tick;
  logic [EOB_HALF_COUNT-1:0] half_sel;
  logic word_a_sel;
  logic word_b_sel;

  eob_refresh_tick #(
    .PERIOD(REFRESH_CYCLES)
  ) eob_refresh_tick_i (
    .mclk(mclk),
    .nrst(nrst),
    .tick(tick)
  );

  // ********************************
  // Decode
  // ********************************
  localparam logic [15:0] HALF_NUM [EOB_HALF_COUNT] = '{EOB_A_LOW_NUM, EOB_A_HIGH_NUM,
    EOB_B_LOW_NUM, EOB_B_HIGH_NUM, EOB_C_LOW_NUM, EOB_C_HIGH_NUM};

  genvar gi;
  generate
    for (gi = 0; gi < EOB_HALF_COUNT; gi++) begin : g_half
      assign half_sel[gi] = (reg_num == HALF_NUM[gi]);
    end
  endgenerate

  assign word_a_sel = (reg_num == EOB_WORD_A_NUM);
  assign word_b_sel = (reg_num == EOB_WORD_B_NUM);
  // C outputs have no word number on purpose
  assign reg_hit = word_a_sel | word_b_sel | (|half_sel);

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    state_next = state_reg;
    // Single storage per output, so all views alias
    if (reg_wr) begin
      if (word_a_sel) begin
        state_next.flags[31:0] = reg_wdata;
      end
      if (word_b_sel) begin
        state_next.flags[63:32] = reg_wdata;
      end
      for (int i = 0; i < EOB_HALF_COUNT; i++) begin
        if (half_sel[i]) begin
          state_next.flags[i*16 +: 16] = reg_wdata[15:0];
        end
      end
    end
    if (reg_rd) begin
      state_next.rdata = '0;
      if (word_a_sel) begin
        state_next.rdata = state_next.flags[31:0];
      end
      if (word_b_sel) begin
        state_next.rdata = state_next.flags[63:32];
      end
      for (int i = 0; i < EOB_HALF_COUNT; i++) begin
        if (half_sel[i]) begin
          state_next.rdata = {16'h0000, state_next.flags[i*16 +: 16]};
        end
      end
    end
    // Pins follow flags only at the refresh, like the module link
    if (tick) begin
      state_next.pins = state_next.flags;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '{flags: EOB_FLAGS_RESET, pins: EOB_FLAGS_RESET, rdata: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata;
  assign ext_out = state_reg.pins;
  assign ext_refresh = tick;

  // ********************************
  // Checks
  // ********************************
  word_a_write_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_wr && word_a_sel |=> state_reg.flags[31:0] == $past(reg_wdata))
    else $error("word A write lost");
  a_low_alias_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_wr && half_sel[0] && !reg_rd ##1 reg_rd && word_a_sel && !reg_wr
    |=> reg_rdata[15:0] == $past(reg_wdata[15:0], 2)) else $error("A low alias broken");
  a_high_alias_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_wr && half_sel[1] |=> state_reg.flags[31:16] == $past(reg_wdata[15:0]))
    else $error("A high alias broken");
  word_b_write_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_wr && word_b_sel |=> state_reg.flags[63:32] == $past(reg_wdata))
    else $error("word B write lost");
  b_high_alias_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_wr && half_sel[3] |=> state_reg.flags[63:48] == $past(reg_wdata[15:0]))
    else $error("B high alias broken");
  c_half_only_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_wr && !half_sel[4] && !half_sel[5]
    |=> state_reg.flags[95:64] == $past(state_reg.flags[95:64]))
    else $error("C flags changed without C half access");
  half_read_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_rd && !reg_wr && half_sel[5] |=> reg_rdata == {16'h0000, state_reg.flags[95:80]})
    else $error("C high read wrong");
  refresh_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    !tick |=> ext_out == $past(ext_out)) else $error("pins moved between refreshes");
  refresh_load_a: assert property (@(posedge mclk) disable iff (!nrst)
    tick && !reg_wr |=> ext_out == $past(state_reg.flags))
    else $error("refresh did not copy flags");

  // ********************************
  // Checks: writes through each view
  // ********************************
  word_a_keep_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_wr && word_a_sel |=> state_reg.flags[95:32] == $past(state_reg.flags[95:32]))
    else $error("word A write touched other flags");
  word_b_keep_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_wr && word_b_sel |=> state_reg.flags[31:0] == $past(state_reg.flags[31:0])
    && state_reg.flags[95:64] == $past(state_reg.flags[95:64]))
    else $error("word B write touched other flags");
  a_low_write_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_wr && half_sel[0] |=> state_reg.flags[15:0] == $past(reg_wdata[15:0]))
    else $error("A low write lost");
  a_low_keep_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_wr && half_sel[0] |=> state_reg.flags[95:16] == $past(state_reg.flags[95:16]))
    else $error("A low write touched other flags");
  a_high_keep_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_wr && half_sel[1] |=> state_reg.flags[15:0] == $past(state_reg.flags[15:0]))
    else $error("A high write touched A low");
  b_low_alias_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_wr && half_sel[2] |=> state_reg.flags[47:32] == $past(reg_wdata[15:0]))
    else $error("B low alias broken");
  c_low_write_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_wr && half_sel[4] |=> state_reg.flags[79:64] == $past(reg_wdata[15:0]))
    else $error("C low write lost");
  c_high_write_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_wr && half_sel[5] |=> state_reg.flags[95:80] == $past(reg_wdata[15:0]))
    else $error("C high write lost");

  // ********************************
  // Checks: reads and refused numbers
  // ********************************
  word_a_read_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_rd && !reg_wr && word_a_sel |=> reg_rdata == $past(state_reg.flags[31:0]))
    else $error("word A read wrong");
  word_b_read_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_rd && !reg_wr && word_b_sel |=> reg_rdata == $past(state_reg.flags[63:32]))
    else $error("word B read wrong");
  half_zero_ext_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_rd && (|half_sel) |=> reg_rdata[31:16] == 16'h0000)
    else $error("half read upper bits not zero");
  read_own_write_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_rd && reg_wr && half_sel[3] |=> reg_rdata[15:0] == $past(reg_wdata[15:0]))
    else $error("read beside write missed the new value");
  rdata_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    !reg_rd |=> reg_rdata == $past(reg_rdata))
    else $error("read data moved without a read");
  // A slip here would let a spare number reach live flags
  unmapped_write_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_wr && !reg_hit |=> state_reg.flags == $past(state_reg.flags))
    else $error("write to unmapped number changed flags");
  unmapped_read_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_rd && !reg_hit |=> reg_rdata == 32'h0000_0000)
    else $error("read of unmapped number not zero");

  // ********************************
  // Checks: refresh
  // ********************************
  refresh_write_a: assert property (@(posedge mclk) disable iff (!nrst)
    tick && reg_wr && word_a_sel |=> ext_out[31:0] == $past(reg_wdata))
    else $error("write in refresh cycle missed the pins");

  // ********************************
  // Coverage
  // ********************************
  word_write_c: cover property (@(posedge mclk) disable iff (!nrst) reg_wr && word_b_sel);
  half_write_c: cover property (@(posedge mclk) disable iff (!nrst) reg_wr && half_sel[4]);
  alias_read_c: cover property (@(posedge mclk) disable iff (!nrst)
    reg_wr && half_sel[1] ##1 reg_rd && word_a_sel);
  refresh_c: cover property (@(posedge mclk) disable iff (!nrst) tick && |state_reg.flags);
  refused_write_c: cover property (@(posedge mclk) disable iff (!nrst) reg_wr && !reg_hit);
endmodule

// >>> dv/eob_module_model.sv
// Behavioural model of one attached output expansion module
`timescale 1ns/1ps
module eob_module_model (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [95:0] ext_out,
  input wire logic ext_refresh,
  output logic [95:0] pins
);
  logic seen;
  // Latches one cycle after the mark, once the bank's copy has landed
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      seen <= 1'b0;
      pins <= 96'h0;
    end else begin
      seen <= ext_refresh;
      if (seen) pins <= ext_out;
    end
  end
endmodule

// >>> dv/test_eob_bank.sv
// Self-checking testbench for the expansion output flag bank
`timescale 1ns/1ps
module test_eob_bank;
  import eob_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_num = 16'h0000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata;
  logic reg_hit;
  logic [95:0] ext_out;
  logic ext_refresh;
  logic [95:0] pins;
  int mismatches = 0;
  int n_checks = 0;
  always #2.5 mclk = ~mclk;
  // Short refresh keeps the run small
  localparam int REF_CYCLES = 8;
  eob_bank #(.REFRESH_CYCLES(REF_CYCLES)) eob_bank_i (.mclk(mclk), .nrst(nrst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_num(reg_num), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_hit(reg_hit), .ext_out(ext_out), .ext_refresh(ext_refresh));
  eob_module_model eob_module_model_i (.mclk(mclk), .nrst(nrst), .ext_out(ext_out),
    .ext_refresh(ext_refresh), .pins(pins));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [95:0] got, input logic [95:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic bus(input logic w, input logic r, input logic [15:0] n, input logic [31:0] d);
    reg_wr = w;
    reg_rd = r;
    reg_num = n;
    reg_wdata = d;
    @(posedge mclk);
    #1;
  endtask
  task automatic rd(input logic [15:0] n, input logic [31:0] e, input logic h);
    bus(1'b0, 1'b1, n, 32'h0000_0000);
    chk("rdata", 96'(reg_rdata), 96'(e));
    chk("hit", 96'(reg_hit), 96'(h));
  endtask
  task automatic wait_ref;
    int i;
    bus(1'b0, 1'b0, 16'h0000, 32'h0000_0000);
    for (i = 0; i < 20 && ext_refresh !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    if (ext_refresh !== 1'b1) begin
      mismatches++;
      end_of_test();
    end
  endtask
  task automatic t_views;
    rd(EOB_WORD_A_NUM, 32'h0000_0000, 1'b1);
    bus(1'b1, 1'b0, EOB_WORD_A_NUM, 32'h8000_0001);
    rd(EOB_A_LOW_NUM, 32'h0000_0001, 1'b1);
    rd(EOB_A_HIGH_NUM, 32'h0000_8000, 1'b1);
    // Upper data bits must be dropped by a half view
    bus(1'b1, 1'b0, EOB_A_HIGH_NUM, 32'hffff_1234);
    rd(EOB_WORD_A_NUM, 32'h1234_0001, 1'b1);
    bus(1'b1, 1'b0, EOB_A_LOW_NUM, 32'hbeef_0002);
    rd(EOB_WORD_A_NUM, 32'h1234_0002, 1'b1);
    bus(1'b1, 1'b0, EOB_WORD_B_NUM, 32'hdead_beef);
    bus(1'b1, 1'b0, EOB_B_LOW_NUM, 32'h0000_5a5a);
    rd(EOB_B_HIGH_NUM, 32'h0000_dead, 1'b1);
    rd(EOB_WORD_B_NUM, 32'hdead_5a5a, 1'b1);
    $display("views test done");
  endtask
  task automatic t_third;
    bus(1'b1, 1'b0, EOB_C_LOW_NUM, 32'h0000_c001);
    bus(1'b1, 1'b0, EOB_C_HIGH_NUM, 32'h0000_8003);
    bus(1'b1, 1'b0, 16'h00fb, 32'hffff_ffff);
    bus(1'b1, 1'b0, 16'h116a, 32'hffff_ffff);
    rd(16'h00fb, 32'h0000_0000, 1'b0);
    rd(EOB_C_LOW_NUM, 32'h0000_c001, 1'b1);
    rd(EOB_C_HIGH_NUM, 32'h0000_8003, 1'b1);
    rd(EOB_WORD_A_NUM, 32'h1234_0002, 1'b1);
    bus(1'b1, 1'b1, EOB_B_HIGH_NUM, 32'h0000_0f0f);
    chk("rd with wr", 96'(reg_rdata), 96'h0f0f);
    $display("third bank test done");
  endtask
  task automatic t_refresh;
    logic [95:0] f;
    f = 96'h8003_c001_0f0f_5a5a_1234_0002;
    wait_ref();
    // Write placed in the refresh cycle reaches the pins at once
    f[31:0] = 32'h0000_00a5;
    bus(1'b1, 1'b0, EOB_WORD_A_NUM, f[31:0]);
    chk("ext_out", ext_out, f);
    bus(1'b1, 1'b0, EOB_WORD_A_NUM, 32'h0000_0000);
    bus(1'b0, 1'b0, 16'h0000, 32'h0000_0000);
    chk("ext_out held", ext_out, f);
    f[31:0] = 32'h0000_0000;
    wait_ref();
    bus(1'b0, 1'b0, 16'h0000, 32'h0000_0000);
    bus(1'b0, 1'b0, 16'h0000, 32'h0000_0000);
    chk("ext_out", ext_out, f);
    chk("pins", pins, f);
    $display("refresh test done");
  endtask
  task automatic t_interval;
    int n;
    wait_ref();
    for (n = 1; n < 20; n++) begin
      @(posedge mclk);
      #1;
      if (ext_refresh === 1'b1) break;
    end
    chk("refresh gap", 96'(n), 96'(REF_CYCLES));
    if (n == 20) end_of_test();
    $display("interval test done");
  endtask
  task automatic t_reset;
    nrst = 1'b0;
    repeat (3) @(posedge mclk);
    #1 nrst = 1'b1;
    chk("ext_out after reset", ext_out, EOB_FLAGS_RESET);
    chk("pins after reset", pins, 96'h0000_0000_0000_0000_0000_0000);
    rd(EOB_WORD_B_NUM, EOB_FLAGS_RESET[63:32], 1'b1);
    $display("reset test done");
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    #1 nrst = 1'b1;
    t_views();
    t_third();
    t_refresh();
    t_interval();
    t_reset();
    end_of_test();
  end
endmodule
